// File: tire_chk.sv
`timescale 1ns/1ps
`default_nettype none
module tire_chk #(
  parameter int OSC_DIV = 2
) (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       mode_sel_lo_i,
  input wire logic       mode_sel_hi_i,
  input wire logic       trim_hv_i,
  input wire logic       serial_clk_i,
  input wire logic       comp_above_i,
  input wire logic [7:0] threshold_reg_o,
  input wire logic       press_power_o,
  input wire logic       temp_power_o,
  input wire logic       mux_press_o,
  input wire logic       mux_temp_o,
  input wire logic       comp_enable_o,
  input wire logic       trim_mode_o,
  input wire logic       out_o,
  input wire logic       host_rst_n_o
);
  // ----
  // checks
  // ----
  int low_cnt;
  always_ff @(posedge clk_i) low_cnt <= host_rst_n_o ? 0 : low_cnt + 1;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  AST_READ: assert property ((mode_sel_lo_i && mode_sel_hi_i && !trim_hv_i) [*3] |-> comp_enable_o
    && !press_power_o && !temp_power_o) else $error("read mode outputs wrong");
  AST_PRESS: assert property ((mode_sel_lo_i && !mode_sel_hi_i && !trim_hv_i) [*5] |-> press_power_o
    && mux_press_o && !mux_temp_o) else $error("pressure path not on");
  AST_TEMP: assert property ((!mode_sel_lo_i && mode_sel_hi_i && !trim_hv_i) [*5] |-> temp_power_o
    && mux_temp_o && !mux_press_o) else $error("temperature path not on");
  AST_PRESS_ORDER: assert property ($fell(press_power_o) |-> !$past(mux_press_o))
    else $error("pressure power off before mux open");
  AST_TEMP_ORDER: assert property ($fell(temp_power_o) |-> !$past(mux_temp_o))
    else $error("temperature power off before mux open");
  AST_TRIM: assert property (trim_hv_i [*3] |-> trim_mode_o && !mux_press_o && !mux_temp_o
    && !comp_enable_o) else $error("trim override missing");
  AST_WAKE_ONE: assert property ((!comp_enable_o && $past(!comp_enable_o) && $fell(out_o))
    ##1 !comp_enable_o |-> out_o) else $error("wake pulse longer than one cycle");
  AST_READ_OUT: assert property (comp_enable_o && $past(comp_enable_o, 2) && !$past(comp_above_i)
    |-> !out_o) else $error("output not following comparator");
  AST_RST_LEN: assert property ($rose(host_rst_n_o) |-> low_cnt == 2 * OSC_DIV)
    else $error("host reset pulse length wrong");
  AST_RST_OUT: assert property ($fell(host_rst_n_o) |-> !out_o)
    else $error("no output pulse with host reset");
  AST_LOAD_FALL: assert property ($changed(threshold_reg_o) |-> !serial_clk_i && $past(!serial_clk_i))
    else $error("threshold loaded off falling edge");
endmodule // tire_chk
bind tire_sensor_mode_and_wake_timer tire_chk #(.OSC_DIV(OSC_DIV)) i_chk (.clk_i, .rstn_i, .mode_sel_lo_i,
  .mode_sel_hi_i, .trim_hv_i, .serial_clk_i, .comp_above_i, .threshold_reg_o, .press_power_o, .temp_power_o,
  .mux_press_o, .mux_temp_o, .comp_enable_o, .trim_mode_o, .out_o, .host_rst_n_o);
`default_nettype wire

// File: tire_divider.sv
`timescale 1ns/1ps
`default_nettype none
module tire_divider #(
  parameter int OSC_DIV     = tire_pkg::OSC_DIV,
  parameter int WAKE_STAGES = tire_pkg::WAKE_STAGES,
  parameter int RST_STAGES  = tire_pkg::RST_STAGES
) (
  input  wire logic clk_i,
  input  wire logic rstn_i,
  output logic      osc_tick_o,
  output logic      wake_pulse_o,
  output logic      host_rst_pulse_o
);
  localparam int CHAIN_W = WAKE_STAGES + RST_STAGES;

  if (OSC_DIV < 1) begin : g_bad_div
    $error("OSC_DIV must be at least 1");
  end
  if (WAKE_STAGES < 1 || RST_STAGES < 1 || CHAIN_W > 32) begin : g_bad_chain
    $error("divider stage counts out of range");
  end

  typedef struct packed {
    logic [31:0]        pre;
    logic [CHAIN_W-1:0] chain;
    logic [1:0]  rst_left;
    logic        wake;
  } div_t;

  div_t st;
  div_t next_st;
  logic tick;

  assign tick = (st.pre == 32'(OSC_DIV - 1));

  // ---------------------------------------------------------------
  // chain
  // ---------------------------------------------------------------
  always_comb begin
    next_st      = st;
    next_st.wake = 1'b0;
    if (tick) begin
      next_st.pre   = 32'h0;
      next_st.chain = st.chain + CHAIN_W'(1);
      if (st.chain[WAKE_STAGES-1:0] == {WAKE_STAGES{1'b1}}) begin
        next_st.wake = 1'b1;
      end
      if (st.chain == {CHAIN_W{1'b1}}) begin
        next_st.rst_left = 2'(tire_pkg::RST_PULSE_TICKS);
      end else if (st.rst_left != 2'h0) begin
        next_st.rst_left = st.rst_left - 2'h1;
      end
    end else begin
      next_st.pre = st.pre + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st.pre      <= 32'h0;
      st.chain    <= CHAIN_W'(tire_pkg::CHAIN_RESET);
      st.rst_left <= 2'h0;
      st.wake     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign osc_tick_o       = tick;
  assign wake_pulse_o     = st.wake;
  assign host_rst_pulse_o = (st.rst_left != 2'h0);
endmodule // tire_divider
`default_nettype wire

// File: tire_mcu.sv
`timescale 1ns/1ps
`default_nettype none
module tire_mcu (
  input  wire logic clk_i,
  output var logic  mode_sel_lo_o,
  output var logic  mode_sel_hi_o,
  output var logic  serial_clk_o,
  output var logic  serial_in_o
);
  // ----
  // pin driver
  // ----
  initial begin
    mode_sel_lo_o = 1'b0;
    mode_sel_hi_o = 1'b0;
    serial_clk_o = 1'b0;
    serial_in_o = 1'b0;
  end
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk_i);
    {mode_sel_hi_o, mode_sel_lo_o} <= m;
  endtask
  task automatic send_bit(input logic b);
    @(posedge clk_i);
    serial_in_o <= b;
    repeat (3) @(posedge clk_i);
    serial_clk_o <= 1'b1;
    repeat (3) @(posedge clk_i);
    serial_clk_o <= 1'b0;
    repeat (3) @(posedge clk_i);
    serial_in_o <= 1'b0;
  endtask
endmodule // tire_mcu
`default_nettype wire

// File: tire_pkg.sv
`default_nettype none
package tire_pkg;
  // ---------------------------------------------------------------
  // clock and divider
  // ---------------------------------------------------------------
  localparam int          CLK_HZ          = 25000000;
  localparam int          OSC_HZ          = 5400;
  localparam int          OSC_DIV         = (CLK_HZ + OSC_HZ - 1) / OSC_HZ;
  localparam int          WAKE_STAGES     = 14;
  localparam int          RST_STAGES      = 10;
  localparam int          CHAIN_W         = WAKE_STAGES + RST_STAGES;
  localparam int          RST_PULSE_TICKS = 2;
  localparam logic [23:0] CHAIN_RESET     = 24'h000000;
  // ---------------------------------------------------------------
  // serial
  // ---------------------------------------------------------------
  localparam int          THR_W           = 8;
  localparam logic [7:0]  THR_RESET       = 8'h00;
  localparam logic [3:0]  BITS_RESET      = 4'h0;
  // ---------------------------------------------------------------
  // mode codes {hi, lo}
  // ---------------------------------------------------------------
  localparam logic [1:0]  MODE_STANDBY    = 2'h0;
  localparam logic [1:0]  MODE_PRESSURE   = 2'h1;
  localparam logic [1:0]  MODE_TEMP       = 2'h2;
  localparam logic [1:0]  MODE_READ       = 2'h3;
endpackage
`default_nettype wire

// File: tire_sensor_mode_and_wake_timer.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - pins hi,lo decode standby, pressure, temperature, read; comparator stage only in read.
// - oscillator and dividers run in every mode; multiplexer closes only in pressure and temperature, threshold shifts only in standby and read.
// - lo only high powers pressure circuit and connects it to sample capacitor.
// - lo falling opens multiplexer first, then pressure circuit powers down.
// - hi only high powers temperature circuit and connects it to capacitor.
// - hi falling opens multiplexer first, then temperature circuit powers down.
// - overvoltage on hi pin enters trim/test mode, overriding normal decoding.
// - oscillator tick at 5.4 kHz, divided by 16384 for the wake pulse.
// - in standby output sits high and pulses low at each wake overflow.
// - in read mode output shows sampled voltage compared with 8-bit threshold.
// - active-low host reset pulses at full 2^24 divider overflow, any mode.
// - each host reset pulse lasts exactly two oscillator cycles.
// - host reset pulse coincides with a wake output pulse.
// - unconnected mode and serial inputs read as low via pull-downs.
// - serial bits on serial_in set the comparator threshold.
// - ten further stages after the wake divider make the host reset.
// - bit counter cleared in measurement modes, counting in standby and read.
// - shift msb first on rising serial clock; load threshold on eighth fall.
module tire_sensor_mode_and_wake_timer #(
  parameter int OSC_DIV     = tire_pkg::OSC_DIV,
  parameter int WAKE_STAGES = tire_pkg::WAKE_STAGES,
  parameter int RST_STAGES  = tire_pkg::RST_STAGES
) (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       mode_sel_lo_i,
  input  wire logic       mode_sel_hi_i,
  input  wire logic       trim_hv_i,
  input  wire logic       serial_clk_i,
  input  wire logic       serial_in_i,
  input  wire logic       comp_above_i,
  output logic [7:0]      threshold_reg_o,
  output logic            press_power_o,
  output logic            temp_power_o,
  output logic            mux_press_o,
  output logic            mux_temp_o,
  output logic            comp_enable_o,
  output logic            trim_mode_o,
  output logic            out_o,
  output logic            host_rst_n_o
);
  if (OSC_DIV < 1) begin : g_bad_div
    $error("OSC_DIV must be at least 1");
  end

  typedef enum logic [3:0] {
    ST_STANDBY  = 4'h1,
    ST_PRESSURE = 4'h2,
    ST_TEMP     = 4'h4,
    ST_READ     = 4'h8
  } mode_t;

  typedef struct packed {
    mode_t mode;
    logic  press_pwr;
    logic  temp_pwr;
    logic  mux_p;
    logic  mux_t;
    logic  trim;
    logic  out;
    logic  rst_n;
  } top_t;

  top_t st;
  top_t next_st;
  logic wake_pulse;
  logic host_rst_pulse;
  logic [1:0] sel;

  function automatic mode_t decode_mode(input logic [1:0] code);
    mode_t m;
    m = ST_STANDBY;
    unique case (code)
      tire_pkg::MODE_STANDBY:  m = ST_STANDBY;
      tire_pkg::MODE_PRESSURE: m = ST_PRESSURE;
      tire_pkg::MODE_TEMP:     m = ST_TEMP;
      tire_pkg::MODE_READ:     m = ST_READ;
    endcase
    return m;
  endfunction

  // pins are pulled down, so an open pin already arrives as 0
  assign sel = {mode_sel_hi_i, mode_sel_lo_i};

  // ---------------------------------------------------------------
  // divider and serial
  // ---------------------------------------------------------------
  tire_divider #(
    .OSC_DIV    (OSC_DIV),
    .WAKE_STAGES(WAKE_STAGES),
    .RST_STAGES (RST_STAGES)
  ) u_div (
    .clk_i           (clk_i),
    .rstn_i          (rstn_i),
    .osc_tick_o      (),
    .wake_pulse_o    (wake_pulse),
    .host_rst_pulse_o(host_rst_pulse)
  );

  tire_serial u_ser (
    .clk_i          (clk_i),
    .rstn_i         (rstn_i),
    .count_clear_i  (sel == tire_pkg::MODE_PRESSURE || sel == tire_pkg::MODE_TEMP),
    .serial_clk_i   (serial_clk_i),
    .serial_in_i    (serial_in_i),
    .threshold_reg_o(threshold_reg_o)
  );

  // ---------------------------------------------------------------
  // mode sequencing
  // ---------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.trim  = trim_hv_i;
    next_st.rst_n = ~host_rst_pulse;
    if (trim_hv_i) begin
      next_st.mode      = ST_STANDBY;
      next_st.mux_p     = 1'b0;
      next_st.mux_t     = 1'b0;
      next_st.press_pwr = st.mux_p;
      next_st.temp_pwr  = st.mux_t;
    end else begin
      next_st.mode = decode_mode(sel);
      // pressure path: open mux one cycle before power off
      if (next_st.mode == ST_PRESSURE) begin
        next_st.press_pwr = 1'b1;
        next_st.mux_p     = st.press_pwr;
      end else begin
        next_st.mux_p     = 1'b0;
        next_st.press_pwr = st.mux_p;
      end
      if (next_st.mode == ST_TEMP) begin
        next_st.temp_pwr = 1'b1;
        next_st.mux_t    = st.temp_pwr;
      end else begin
        next_st.mux_t    = 1'b0;
        next_st.temp_pwr = st.mux_t;
      end
    end
    unique case (next_st.mode)
      ST_STANDBY:  next_st.out = ~wake_pulse;
      ST_READ:     next_st.out = comp_above_i & ~wake_pulse;
      ST_PRESSURE: next_st.out = ~wake_pulse;
      ST_TEMP:     next_st.out = ~wake_pulse;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st.mode      <= ST_STANDBY;
      st.press_pwr <= 1'b0;
      st.temp_pwr  <= 1'b0;
      st.mux_p     <= 1'b0;
      st.mux_t     <= 1'b0;
      st.trim      <= 1'b0;
      st.out       <= 1'b1;
      st.rst_n     <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign press_power_o = st.press_pwr;
  assign temp_power_o  = st.temp_pwr;
  assign mux_press_o   = st.mux_p;
  assign mux_temp_o    = st.mux_t;
  assign comp_enable_o = (st.mode == ST_READ) && !st.trim;
  assign trim_mode_o   = st.trim;
  assign out_o         = st.out;
  assign host_rst_n_o  = st.rst_n;
endmodule // tire_sensor_mode_and_wake_timer
`default_nettype wire

// File: tire_sensor_mode_and_wake_timer_test.sv
`timescale 1ns/1ps
`default_nettype none
module tire_sensor_mode_and_wake_timer_test;
  // ----
  // bench
  // ----
  localparam int DIV = 2;
  localparam int RST_STG = 1;
  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       trim_hv_i = 1'b0;
  logic       comp_above_i = 1'b0;
  wire logic  lo, hi, sck, serial_in, pp, tp, mp, mt, ce, tm, out, hr;
  wire logic [7:0] thr;
  int         n_errors = 0;
  int         n_compared = 0;
  int         cyc = 0;
  int         t1;
  logic [31:0] seed = 32'h1bd1827a;
  logic [7:0] v = 8'h00;
  logic [7:0] thr_prev = 8'h00;
  logic [7:0] exp_q[$];
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) cyc <= cyc + 1;
  tire_mcu i_mcu (.clk_i(clk_i), .mode_sel_lo_o(lo), .mode_sel_hi_o(hi), .serial_clk_o(sck), .serial_in_o(serial_in));
  tire_sensor_mode_and_wake_timer #(.OSC_DIV(DIV), .RST_STAGES(RST_STG))
    i_dut (.clk_i(clk_i), .rstn_i(rstn_i), .mode_sel_lo_i(lo),
    .mode_sel_hi_i(hi), .trim_hv_i(trim_hv_i), .serial_clk_i(sck), .serial_in_i(serial_in), .comp_above_i(comp_above_i),
    .threshold_reg_o(thr), .press_power_o(pp), .temp_power_o(tp), .mux_press_o(mp), .mux_temp_o(mt),
    .comp_enable_o(ce), .trim_mode_o(tm), .out_o(out), .host_rst_n_o(hr));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic mode(input logic [1:0] m);
    i_mcu.set_mode(m);
    repeat (6) @(posedge clk_i);
    #1;
    check("power", {6'h0, pp, tp}, {6'h0, m == tire_pkg::MODE_PRESSURE, m == tire_pkg::MODE_TEMP});
    check("mux", {6'h0, mp, mt}, {6'h0, m == tire_pkg::MODE_PRESSURE, m == tire_pkg::MODE_TEMP});
    check("comp_enable", {7'h0, ce}, {7'h0, m == tire_pkg::MODE_READ});
  endtask
  task automatic send_top(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n; i--) i_mcu.send_bit(b[i]);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic next_byte;
    seed = lfsr(seed);
    v = v ^ {seed[7:1], 1'b1};
  endtask
  task automatic wait_out(input logic lvl);
    for (int k = 0; out !== lvl; k++) begin
      @(posedge clk_i);
      #1;
      if (k > 40000) begin
        n_errors++;
        wrap_up();
      end
    end
  endtask
  always @(posedge clk_i) begin
    #1;
    if (rstn_i && thr !== thr_prev)
      check("threshold_reg", thr, exp_q.size() ? exp_q.pop_front() : thr_prev);
    thr_prev = thr;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    #1;
    check("reset outputs", {4'h0, out, hr, pp, mp}, 8'h0c);
    for (int m = 0; m < 4; m++) mode(2'(m));
    mode(tire_pkg::MODE_STANDBY);
    next_byte();
    exp_q.push_back(v);
    send_top(v, 8);
    send_top(8'h5a, 5);
    mode(tire_pkg::MODE_PRESSURE);
    mode(tire_pkg::MODE_STANDBY);
    next_byte();
    exp_q.push_back(v);
    send_top(v, 8);
    next_byte();
    exp_q.push_back(v);
    send_top(v, 4);
    mode(tire_pkg::MODE_READ);
    send_top(v << 4, 4);
    for (int i = 0; i < 6; i++) begin
      next_byte();
      @(posedge clk_i);
      comp_above_i <= seed[0];
      repeat (3) @(posedge clk_i);
      #1;
      check("read out", {7'h0, out}, {7'h0, seed[0]});
    end
    @(posedge clk_i);
    trim_hv_i <= 1'b1;
    i_mcu.set_mode(tire_pkg::MODE_PRESSURE);
    repeat (6) @(posedge clk_i);
    #1;
    check("trim", {4'h0, tm, mp, mt, ce}, 8'h08);
    @(posedge clk_i);
    trim_hv_i <= 1'b0;
    mode(tire_pkg::MODE_STANDBY);
    check("standby out", {7'h0, out}, 8'h01);
    wait_out(1'b0);
    t1 = cyc;
    wait_out(1'b1);
    wait_out(1'b0);
    check("wake period", {7'h0, (cyc - t1) == 16384 * DIV}, 8'h01);
    check("host reset with wake", {7'h0, hr}, 8'h00);
    t1 = cyc;
    for (int k = 0; k < 16 && hr !== 1'b1; k++) begin
      @(posedge clk_i);
      #1;
    end
    check("host reset width", 8'(cyc - t1), 8'(tire_pkg::RST_PULSE_TICKS * DIV));
    check("host reset idle", {7'h0, hr}, 8'h01);
    check("pending loads", 8'(exp_q.size()), 8'h00);
    wrap_up();
  end
endmodule // tire_sensor_mode_and_wake_timer_test
`default_nettype wire

// File: tire_serial.sv
`timescale 1ns/1ps
`default_nettype none
module tire_serial (
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  input  wire logic       count_clear_i,
  input  wire logic       serial_clk_i,
  input  wire logic       serial_in_i,
  output logic [7:0]      threshold_reg_o
);
  typedef struct packed {
    logic [7:0] shift;
    logic [7:0] thr;
    logic [3:0] bits;
    logic       clk_q;
  } ser_t;

  ser_t st;
  ser_t next_st;

  // ---------------------------------------------------------------
  // shift and load
  // ---------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.clk_q = serial_clk_i;
    if (count_clear_i) begin
      next_st.bits = tire_pkg::BITS_RESET;
    end else if (serial_clk_i && !st.clk_q) begin
      next_st.shift = {st.shift[6:0], serial_in_i};
    end else if (!serial_clk_i && st.clk_q) begin
      if (st.bits == 4'h7) begin
        next_st.thr  = st.shift;
        next_st.bits = 4'h0;
      end else begin
        next_st.bits = st.bits + 4'h1;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      st.shift <= tire_pkg::THR_RESET;
      st.thr   <= tire_pkg::THR_RESET;
      st.bits  <= tire_pkg::BITS_RESET;
      st.clk_q <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign threshold_reg_o = st.thr;
endmodule // tire_serial
`default_nettype wire
